// ### rtl/hpc_device.sv
// device end: host port decode, straps, irq and 8-bit mode pins
// Functional notes
// - read strobe low active, polarity configurable
// - write strobe low active, polarity configurable
// - chip select qualifies accesses, polarity configurable
// - port select high data, low index
// - irq high active, config or strap inverts
// - upper pins data in 16-bit, else alternates
// - wake pin driven once straps taken, high on wake event
// - led mode 1: low on full duplex
// - led mode 0: low on 10M
// - three outputs set by register 1Fh
// - gp6 strap selects open-drain irq
// - three bidirectional pins, inputs after reset
// - irq polarity strap high means low active
// - bus width strap high means 8-bit
// - wake strap sets chip select polarity
`timescale 1ns/100ps
`default_nettype none
`include "hpc_defs.svh"

module hpc_device (
    input  wire logic        clk_in,         // 250 MHz clock
    input  wire logic        srst_in,        // sync reset, high
    hpc_if.device            pins,           // host side pins
    input  wire logic        cfg_rd_hi_in,   // read strobe active high
    input  wire logic        cfg_wr_hi_in,   // write strobe active high
    input  wire logic        cfg_cs_hi_in,   // cs active high, 16-bit
    input  wire logic        cfg_irq_lo_in,  // irq active low
    input  wire logic        led_mode_in,    // led mode
    input  wire logic        irq_in,         // interrupt request level
    input  wire logic        wake_event_in,  // wake up event level
    input  wire logic        full_duplex_in, // phy full duplex
    input  wire logic        speed_10m_in,   // phy at 10M
    input  wire logic [15:0] reg_rdata_in,   // register read data
    output logic [7:0]       reg_addr_out,   // selected register
    output logic             reg_wr_out,     // register write pulse
    output logic [15:0]      reg_wdata_out,  // register write data
    output logic             reg_rd_out,     // register read pulse
    output logic             bus8_out,       // 8-bit mode active
    output logic             strap_ok_out    // straps taken
);
    hpc_pkg::hpc_dev_st_t s;
    hpc_pkg::hpc_dev_st_t next_s;
    logic                 cs_hi;
    logic                 cs_act;
    logic                 rd_act;
    logic                 wr_act;
    logic                 rd_rise;
    logic                 wr_fall;
    logic                 led_on;
    logic                 irq_level;
    hpc_pkg::hpc_sel_t    sel;
    logic [7:0]           gp_rb;

    //////////////////////////////////////////////////////////////////////
    // register number decode, used for read and write
    function automatic hpc_pkg::hpc_sel_t gp_sel(input logic [7:0] i);
        if (i == `HPC_IDX_GP_DIR) begin
            return hpc_pkg::hpc_sel_dir;
        end else if (i == `HPC_IDX_GP_VAL) begin
            return hpc_pkg::hpc_sel_val;
        end else begin
            return hpc_pkg::hpc_sel_ext;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////
    // strobe qualification on synchronised pins
    // strap chip select
    assign cs_hi = s.mode8 ? s.cs_strap_hi : cfg_cs_hi_in;
    assign cs_act = s.sok & ~(s.ctl_s2[3] ^ cs_hi);
    assign rd_act = cs_act & ~(s.ctl_s2[2] ^ cfg_rd_hi_in);
    assign wr_act = cs_act & ~(s.ctl_s2[1] ^ cfg_wr_hi_in);
    assign rd_rise = rd_act & ~s.rd_prev;
    assign wr_fall = ~wr_act & s.wr_prev;
    assign sel = gp_sel(s.idx);

    // value register readback, inputs show pin level
    always_comb begin
        gp_rb = s.gval;
        gp_rb[`HPC_REG_GPIO_LSB +: 3] =
            (s.gdir[`HPC_REG_GPIO_LSB +: 3] & s.gval[`HPC_REG_GPIO_LSB +: 3])
            | (~s.gdir[`HPC_REG_GPIO_LSB +: 3] & s.d_s2[8 + `HPC_HI_GPIO_LSB +: 3]);
    end

    assign led_on = led_mode_in ? full_duplex_in : speed_10m_in;
    assign irq_level = irq_in ^ (s.irq_lo | cfg_irq_lo_in);

    //////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        next_s.ctl_s1 = {pins.cs, pins.rd, pins.wr, pins.cmd};
        next_s.ctl_s2 = s.ctl_s1;
        next_s.d_s1 = {pins.host_data_high, pins.host_data_low};
        next_s.d_s2 = s.d_s1;
        next_s.st_s1 = {pins.bus_width_strap, pins.irq_polarity_strap};
        next_s.st_s2 = s.st_s1;
        next_s.reg_wr = 1'b0;
        next_s.rd_prev = rd_act;
        next_s.wr_prev = wr_act;
        next_s.drv = rd_act;

        // strap capture after the synchroniser fills
        if (!s.sok) begin
            next_s.scnt = s.scnt + 2'h1;
            if (s.scnt == `HPC_STRAP_WAIT) begin
                next_s.sok = 1'b1;
                next_s.mode8 = s.st_s2[1];
                next_s.irq_lo = s.st_s2[0];
                next_s.irq_od = s.st_s2[1] & s.d_s2[8 + `HPC_HI_GP6];
                next_s.cs_strap_hi = s.d_s2[8 + `HPC_HI_WAKE];
            end
        end

        // hold write data and port while strobe active
        if (wr_act) begin
            next_s.wd = s.d_s2;
            next_s.wcmd = s.ctl_s2[0];
        end

        // write takes effect as the strobe ends
        if (wr_fall) begin
            if (!s.wcmd) begin
                next_s.idx = s.wd[7:0];
            end else if (sel == hpc_pkg::hpc_sel_dir) begin
                next_s.gdir = s.wd[7:0];
            end else if (sel == hpc_pkg::hpc_sel_val) begin
                next_s.gval = s.wd[7:0];
            end else begin
                next_s.reg_wr = 1'b1;
                next_s.reg_wd = s.mode8 ? {8'h00, s.wd[7:0]} : s.wd;
            end
        end

        // read data is taken as the strobe starts
        if (rd_rise) begin
            if (!s.ctl_s2[0]) begin
                next_s.dout = {8'h00, s.idx};
            end else if (sel == hpc_pkg::hpc_sel_dir) begin
                next_s.dout = {8'h00, s.gdir};
            end else if (sel == hpc_pkg::hpc_sel_val) begin
                next_s.dout = {8'h00, gp_rb};
            end else begin
                next_s.dout = s.mode8 ? {8'h00, reg_rdata_in[7:0]} : reg_rdata_in;
            end
        end

        // upper pins released until straps taken
        next_s.hi_out = 8'h00;
        next_s.hi_oe_n = 8'hff;
        if (s.sok) begin
            if (!s.mode8) begin
                next_s.hi_out = next_s.dout[15:8];
                next_s.hi_oe_n = {8{~rd_act}};
            end else begin
                next_s.hi_out[`HPC_HI_GPIO_LSB +: 3] = s.gval[`HPC_REG_GPIO_LSB +: 3];
                next_s.hi_oe_n[`HPC_HI_GPIO_LSB +: 3] = ~s.gdir[`HPC_REG_GPIO_LSB +: 3];
                next_s.hi_out[`HPC_HI_GPO_LSB +: 3] = s.gval[`HPC_REG_GPO_LSB +: 3];
                next_s.hi_oe_n[`HPC_HI_GPO_LSB +: 3] = 3'h0;
                next_s.hi_oe_n[`HPC_HI_LED] = ~led_on;
                next_s.hi_out[`HPC_HI_WAKE] = wake_event_in;
                next_s.hi_oe_n[`HPC_HI_WAKE] = 1'b0;
            end
        end

        next_s.irq_out = irq_level;
        next_s.irq_oe_n = ~s.sok | (s.irq_od & irq_level);
    end

    // state register, io pins come up as inputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s <= '0;
            s.irq_oe_n <= 1'b1;
            s.hi_oe_n <= 8'hff;
            s.gdir <= `HPC_GP_DIR_RST;
            s.gval <= `HPC_GP_VAL_RST;
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs
    assign pins.dev_lo_out = s.dout[7:0];
    assign pins.dev_lo_oe_n = {8{~s.drv}};
    assign pins.dev_hi_out = s.hi_out;
    assign pins.dev_hi_oe_n = s.hi_oe_n;
    assign pins.dev_irq_out = s.irq_out;
    assign pins.dev_irq_oe_n = s.irq_oe_n;
    assign reg_addr_out = s.idx;
    assign reg_wr_out = s.reg_wr;
    assign reg_wdata_out = s.reg_wd;
    assign reg_rd_out = rd_rise & s.ctl_s2[0] & (sel == hpc_pkg::hpc_sel_ext);
    assign bus8_out = s.mode8;
    assign strap_ok_out = s.sok;
endmodule // hpc_device

`default_nettype wire

// ### inc/hpc_defs.svh
// constants shared by the host port pin ends
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

// register indices served inside the device
`define HPC_IDX_GP_DIR 8'h1e
`define HPC_IDX_GP_VAL 8'h1f

// general purpose register reset values
`define HPC_GP_DIR_RST 8'h00
`define HPC_GP_VAL_RST 8'h00

// general purpose register field positions
`define HPC_REG_GPIO_LSB 1
`define HPC_REG_GPO_LSB  4

// upper data pin positions in 8-bit mode
`define HPC_HI_GPIO_LSB 0
`define HPC_HI_GPO_LSB  3
`define HPC_HI_GP6      5
`define HPC_HI_LED      6
`define HPC_HI_WAKE     7

// strap capture delay
`define HPC_STRAP_WAIT 2'h2

// host cycle timing in 4 ns clocks: 8, 40 and 16 ns
`define HPC_SETUP_CYC  2
`define HPC_STROBE_CYC 10
`define HPC_HOLD_CYC   4

`endif

// ### inc/hpc_pkg.sv
// types of the host port pin ends
package hpc_pkg;

    // register selected by the index
    typedef enum logic [1:0] {
        hpc_sel_ext = 2'b00,
        hpc_sel_dir = 2'b01,
        hpc_sel_val = 2'b10
    } hpc_sel_t;

    // host access sequencer
    typedef enum logic [1:0] {
        hpc_s_idle   = 2'b00,
        hpc_s_setup  = 2'b01,
        hpc_s_strobe = 2'b10,
        hpc_s_hold   = 2'b11
    } hpc_hst_t;

    // all state of the device end
    typedef struct packed {
        logic [1:0]  scnt;
        logic        sok;
        logic        mode8;
        logic        cs_strap_hi;
        logic        irq_lo;
        logic        irq_od;
        logic [3:0]  ctl_s1;
        logic [3:0]  ctl_s2;
        logic [15:0] d_s1;
        logic [15:0] d_s2;
        logic [1:0]  st_s1;
        logic [1:0]  st_s2;
        logic        rd_prev;
        logic        wr_prev;
        logic        wcmd;
        logic [15:0] wd;
        logic [7:0]  idx;
        logic [7:0]  gdir;
        logic [7:0]  gval;
        logic [15:0] dout;
        logic        drv;
        logic        reg_wr;
        logic [15:0] reg_wd;
        logic [7:0]  hi_out;
        logic [7:0]  hi_oe_n;
        logic        irq_out;
        logic        irq_oe_n;
    } hpc_dev_st_t;

    // all state of the host end
    typedef struct packed {
        hpc_hst_t    st;
        logic [3:0]  cnt;
        logic        wr;
        logic        act_cs;
        logic        act_rd;
        logic        act_wr;
        logic        cmd;
        logic [15:0] wd;
        logic        drive;
        logic [15:0] rdata;
        logic        rvalid;
        logic [15:0] d_s1;
        logic [15:0] d_s2;
        logic        irq_s1;
        logic        irq_s2;
    } hpc_hst_st_t;

endpackage

// ### inc/hpc_if.sv
// pin bundle between host processor and device
`timescale 1ns/100ps
`default_nettype none

interface hpc_if;
    logic        cs;                 // chip select level
    logic        rd;                 // host_read_strobe level
    logic        wr;                 // host_write_strobe level
    logic        cmd;                // port select, high data
    logic [7:0]  host_lo_out;
    logic [7:0]  host_lo_oe_n;
    logic [7:0]  host_hi_out;
    logic [7:0]  host_hi_oe_n;
    logic [7:0]  dev_lo_out;
    logic [7:0]  dev_lo_oe_n;
    logic [7:0]  dev_hi_out;
    logic [7:0]  dev_hi_oe_n;
    logic        dev_irq_out;
    logic        dev_irq_oe_n;
    logic        bus_width_strap;    // set by bench
    logic        irq_polarity_strap; // set by bench
    logic [7:0]  hi_pull;            // level of floating upper pins
    logic        irq_pull;           // level of floating irq
    logic [7:0]  host_data_low;
    logic [7:0]  host_data_high;
    logic        irq;

    // wire levels, undriven low pins pull low
    assign host_data_low = (~dev_lo_oe_n & dev_lo_out)
                         | (dev_lo_oe_n & ~host_lo_oe_n & host_lo_out);
    assign host_data_high = (~dev_hi_oe_n & dev_hi_out)
                          | (dev_hi_oe_n & ~host_hi_oe_n & host_hi_out)
                          | (dev_hi_oe_n & host_hi_oe_n & hi_pull);
    assign irq = dev_irq_oe_n ? irq_pull : dev_irq_out;

    modport device (
        input  cs, rd, wr, cmd, host_data_low, host_data_high,
        input  bus_width_strap, irq_polarity_strap,
        output dev_lo_out, dev_lo_oe_n, dev_hi_out, dev_hi_oe_n,
        output dev_irq_out, dev_irq_oe_n
    );

    modport host (
        output cs, rd, wr, cmd, host_lo_out, host_lo_oe_n,
        output host_hi_out, host_hi_oe_n,
        input  host_data_low, host_data_high, irq
    );
endinterface

`default_nettype wire

// ### rtl/hpc_host.sv
// host processor end: drives access cycles on the pins
`timescale 1ns/100ps
`default_nettype none
`include "hpc_defs.svh"

module hpc_host (
    input  wire logic        clk_in,          // 250 MHz clock
    input  wire logic        srst_in,         // sync reset, high
    hpc_if.host              pins,            // device pins
    input  wire logic        rd_hi_in,        // read strobe active high
    input  wire logic        wr_hi_in,        // write strobe active high
    input  wire logic        cs_hi_in,        // chip select active high
    input  wire logic        bus16_in,        // drive upper data pins
    input  wire logic        irq_lo_in,       // irq pin active low
    input  wire logic        req_valid_in,    // access request
    input  wire logic        req_write_in,    // 1 write, 0 read
    input  wire logic        req_cmd_in,      // 1 data port, 0 index port
    input  wire logic [15:0] req_wdata_in,    // write data
    output logic             req_ready_out,   // request taken when high
    output logic [15:0]      rdata_out,       // read data
    output logic             rdata_valid_out, // read data pulse
    output logic             irq_out          // synchronised interrupt
);
    hpc_pkg::hpc_hst_st_t s;
    hpc_pkg::hpc_hst_st_t next_s;

    //////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        next_s = s;
        next_s.d_s1 = {pins.host_data_high, pins.host_data_low};
        next_s.d_s2 = s.d_s1;
        next_s.irq_s1 = pins.irq;
        next_s.irq_s2 = s.irq_s1;
        next_s.rvalid = 1'b0;
        next_s.cnt = s.cnt - 4'h1;
        case (s.st)
            hpc_pkg::hpc_s_idle: begin
                next_s.cnt = 4'h0;
                if (req_valid_in) begin
                    next_s.wr = req_write_in;
                    next_s.cmd = req_cmd_in;
                    next_s.wd = req_wdata_in;
                    next_s.drive = req_write_in;
                    next_s.act_cs = 1'b1;
                    next_s.cnt = 4'(`HPC_SETUP_CYC - 1);
                    next_s.st = hpc_pkg::hpc_s_setup;
                end
            end
            hpc_pkg::hpc_s_setup: begin
                if (s.cnt == 4'h0) begin
                    next_s.act_rd = ~s.wr;
                    next_s.act_wr = s.wr;
                    next_s.cnt = 4'(`HPC_STROBE_CYC - 1);
                    next_s.st = hpc_pkg::hpc_s_strobe;
                end
            end
            hpc_pkg::hpc_s_strobe: begin
                if (s.cnt == 4'h0) begin
                    next_s.act_rd = 1'b0;
                    next_s.act_wr = 1'b0;
                    if (!s.wr) begin
                        next_s.rdata = bus16_in ? s.d_s2 : {8'h00, s.d_s2[7:0]};
                        next_s.rvalid = 1'b1;
                    end
                    next_s.cnt = 4'(`HPC_HOLD_CYC - 1);
                    next_s.st = hpc_pkg::hpc_s_hold;
                end
            end
            hpc_pkg::hpc_s_hold: begin
                if (s.cnt == 4'h0) begin
                    next_s.act_cs = 1'b0;
                    next_s.drive = 1'b0;
                    next_s.st = hpc_pkg::hpc_s_idle;
                end
            end
            default: next_s.st = hpc_pkg::hpc_s_idle;
        endcase
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // pin levels
    // chip select polarity
    assign pins.cs = s.act_cs ~^ cs_hi_in;
    assign pins.rd = s.act_rd ~^ rd_hi_in;
    assign pins.wr = s.act_wr ~^ wr_hi_in;
    assign pins.cmd = s.cmd;
    assign pins.host_lo_out = s.wd[7:0];
    assign pins.host_lo_oe_n = {8{~s.drive}};
    assign pins.host_hi_out = s.wd[15:8];
    assign pins.host_hi_oe_n = {8{~(s.drive & bus16_in)}};

    // user side answers
    assign req_ready_out = (s.st == hpc_pkg::hpc_s_idle);
    assign rdata_out = s.rdata;
    assign rdata_valid_out = s.rvalid;
    assign irq_out = s.irq_s2 ^ irq_lo_in;
endmodule // hpc_host

`default_nettype wire

// ### testbench/hpc_checker.sv
// concurrent checks on the pins between host and device
`timescale 1ns/100ps
`default_nettype none

module hpc_checker (
    input  wire logic       clk_in,          // bench clock
    input  wire logic       srst_in,         // sync reset, high
    input  wire logic       cmd,             // port select level
    input  wire logic       rd,              // read strobe level
    input  wire logic       wr,              // write strobe level
    input  wire logic [7:0] host_lo_oe_n,    // host low byte drive
    input  wire logic [7:0] dev_lo_oe_n,     // device low byte drive
    input  wire logic [7:0] dev_hi_out,      // device upper pin values
    input  wire logic [7:0] dev_hi_oe_n,     // device upper pin drive
    input  wire logic       dev_irq_out,     // irq pin value
    input  wire logic       dev_irq_oe_n,    // irq pin drive
    input  wire logic       bus_width_strap, // width strap level
    input  wire logic [7:0] hi_pull          // upper pin strap levels
);
    logic [2:0] rel_cnt;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    //////////////////////////////////////////////////////////////////////
    // cycles since reset release, saturating
    always_ff @(posedge clk_in) begin
        rel_cnt <= srst_in ? 3'h0 : rel_cnt + 3'(rel_cnt != 3'h7);
    end

    //////////////////////////////////////////////////////////////////////
    // read drive window of the device
    sequence s_drive_on;
        $fell(dev_lo_oe_n[0]);
    endsequence
    sequence s_drive_off;
        $rose(dev_lo_oe_n[0]);
    endsequence

    property p_reset_quiet;
        $fell(srst_in) |-> dev_lo_oe_n == 8'hff && dev_hi_oe_n == 8'hff && dev_irq_oe_n;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("device drives after reset");

    property p_no_clash;
        dev_lo_oe_n != 8'hff |-> host_lo_oe_n == 8'hff;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("low data driven by both ends");

    property p_drive_bound;
        s_drive_on |-> ##[1:20] s_drive_off;
    endproperty
    a_drive_bound: assert property (p_drive_bound) else $error("read drive not released");

    property p_wr_data;
        $changed(wr) |-> host_lo_oe_n == 8'h00 && dev_lo_oe_n == 8'hff;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write strobe moves without data");

    property p_cmd_steady;
        $changed(cmd) |-> $stable(rd) && $stable(wr);
    endproperty
    a_cmd_steady: assert property (p_cmd_steady) else $error("port select moves with strobe");

    property p_wide_pair;
        !bus_width_strap |-> dev_hi_oe_n == dev_lo_oe_n;
    endproperty
    a_wide_pair: assert property (p_wide_pair) else $error("upper pins not paired with data");

    property p_wake_drive;
        bus_width_strap && rel_cnt == 3'h7 |-> !dev_hi_oe_n[7];
    endproperty
    a_wake_drive: assert property (p_wake_drive) else $error("wake pin not driven");

    property p_led_low;
        bus_width_strap && !dev_hi_oe_n[6] |-> !dev_hi_out[6];
    endproperty
    a_led_low: assert property (p_led_low) else $error("led pin driven high");

    property p_gpo_drive;
        bus_width_strap && rel_cnt == 3'h7 |-> dev_hi_oe_n[5:3] == 3'h0;
    endproperty
    a_gpo_drive: assert property (p_gpo_drive) else $error("general outputs not driven");

    property p_gpio_input;
        bus_width_strap && $fell(srst_in) |-> (dev_hi_oe_n[2:0] == 3'h7) [*8];
    endproperty
    a_gpio_input: assert property (p_gpio_input) else $error("io pins driven after reset");

    property p_open_drain;
        bus_width_strap && hi_pull[5] && rel_cnt == 3'h7 && !dev_irq_oe_n |-> !dev_irq_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain irq driven high");
endmodule // hpc_checker

`default_nettype wire

// ### testbench/host_port_pin_config_tb.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
`default_nettype none
`include "hpc_defs.svh"

`define TB_CHK(name, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
end

module host_port_pin_config_tb;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        pol, h_cs, d_cs, bus16 = 1'b1;
    logic        cfg_irq_lo, h_irq_lo, led_mode;
    logic        irq_req, wake_ev, fdx, spd10;
    logic [15:0] reg_rdata = 16'h0000;
    logic        req_valid = 1'b0, req_write = 1'b0, req_cmd = 1'b0;
    logic [15:0] req_wdata = 16'h0000;
    logic        req_ready, rdata_valid, irq_host, reg_wr, reg_rd, bus8, strap_ok;
    logic [15:0] rdata, reg_wdata, last_wd;
    logic [7:0]  reg_addr;
    int          fails = 0, tests_run = 0, wr_cnt = 0, rd_cnt = 0, rv_cnt = 0;

    hpc_if hpc_if_inst ();

    hpc_host hpc_host_inst (.clk_in(clk_in), .srst_in(srst_in), .pins(hpc_if_inst),
        .rd_hi_in(pol), .wr_hi_in(pol), .cs_hi_in(h_cs), .bus16_in(bus16),
        .irq_lo_in(h_irq_lo), .req_valid_in(req_valid), .req_write_in(req_write),
        .req_cmd_in(req_cmd), .req_wdata_in(req_wdata), .req_ready_out(req_ready),
        .rdata_out(rdata), .rdata_valid_out(rdata_valid), .irq_out(irq_host));

    hpc_device hpc_device_inst (.clk_in(clk_in), .srst_in(srst_in), .pins(hpc_if_inst),
        .cfg_rd_hi_in(pol), .cfg_wr_hi_in(pol), .cfg_cs_hi_in(d_cs),
        .cfg_irq_lo_in(cfg_irq_lo), .led_mode_in(led_mode), .irq_in(irq_req),
        .wake_event_in(wake_ev), .full_duplex_in(fdx), .speed_10m_in(spd10),
        .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
        .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd), .bus8_out(bus8),
        .strap_ok_out(strap_ok));

    hpc_checker hpc_checker_inst (.clk_in(clk_in), .srst_in(srst_in),
        .cmd(hpc_if_inst.cmd), .rd(hpc_if_inst.rd), .wr(hpc_if_inst.wr),
        .host_lo_oe_n(hpc_if_inst.host_lo_oe_n), .dev_lo_oe_n(hpc_if_inst.dev_lo_oe_n),
        .dev_hi_out(hpc_if_inst.dev_hi_out), .dev_hi_oe_n(hpc_if_inst.dev_hi_oe_n),
        .dev_irq_out(hpc_if_inst.dev_irq_out), .dev_irq_oe_n(hpc_if_inst.dev_irq_oe_n),
        .bus_width_strap(hpc_if_inst.bus_width_strap), .hi_pull(hpc_if_inst.hi_pull));

    //////////////////////////////////////////////////////////////////////
    // clock and pulse counters
    always #2 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        rd_cnt += (reg_rd === 1'b1);
        rv_cnt += (rdata_valid === 1'b1);
        if (reg_wr === 1'b1) begin
            wr_cnt++;
            last_wd = reg_wdata;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // reset with straps applied
    task automatic do_reset(input logic bw, input logic ipol, input logic p,
                            input logic hcs, input logic dcs, input logic [7:0] pull);
        @(negedge clk_in);
        srst_in = 1'b1;
        pol = p;
        h_cs = hcs;
        d_cs = dcs;
        hpc_if_inst.bus_width_strap = bw;
        hpc_if_inst.irq_polarity_strap = ipol;
        hpc_if_inst.hi_pull = pull;
        repeat (12) @(negedge clk_in);
        srst_in = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask

    // one host access
    task automatic acc(input logic w, input logic c, input logic [15:0] d);
        int n = 0;
        int rv = rv_cnt;
        @(negedge clk_in);
        req_valid = 1'b1;
        req_write = w;
        req_cmd = c;
        req_wdata = d;
        @(negedge clk_in);
        req_valid = 1'b0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        `TB_CHK("ready", 1'b1, req_ready);
        `TB_CHK("read pulse", rv + !w, rv_cnt);
        repeat (4) @(negedge clk_in);
    endtask

    task automatic wr_idx(input logic [7:0] idx, input logic [15:0] d);
        acc(1'b1, 1'b0, {8'h00, idx});
        acc(1'b1, 1'b1, d);
    endtask

    //////////////////////////////////////////////////////////////////////
    // index and data accesses, 16-bit
    task automatic t_access(input logic p);
        int wc;
        logic [7:0] idx = p ? 8'h0a : 8'h05;
        logic [15:0] dat = p ? 16'h5a3c : 16'ha5c3;
        do_reset(1'b0, 1'b0, p, p, p, 8'h00);
        `TB_CHK("strap_ok", 1'b1, strap_ok);
        `TB_CHK("bus8", 1'b0, bus8);
        wc = wr_cnt;
        wr_idx(idx, dat);
        `TB_CHK("reg_addr", idx, reg_addr);
        `TB_CHK("write count", wc + 1, wr_cnt);
        `TB_CHK("write data", dat, last_wd);
        reg_rdata = ~dat;
        wc = rd_cnt;
        acc(1'b0, 1'b1, 16'h0000);
        `TB_CHK("read data", ~dat, rdata);
        `TB_CHK("reg read", wc + 1, rd_cnt);
        acc(1'b0, 1'b0, 16'h0000);
        `TB_CHK("index read", idx, rdata[7:0]);
    endtask

    // chip select inactive refuses access
    task automatic t_refuse();
        int wc;
        do_reset(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        wc = wr_cnt;
        wr_idx(8'h33, 16'hbeef);
        `TB_CHK("refused index", 8'h00, reg_addr);
        `TB_CHK("refused write", wc, wr_cnt);
    endtask

    // irq polarity from config and from strap
    task automatic t_irq();
        for (int s = 0; s < 2; s++) begin
            do_reset(1'b0, s[0], 1'b0, 1'b0, 1'b0, 8'h00);
            for (int i = 0; i < 4; i++) begin
                irq_req = i[0];
                cfg_irq_lo = i[1];
                h_irq_lo = i[1] | s[0];
                repeat (6) @(negedge clk_in);
                `TB_CHK("irq pin", i[0] ^ (i[1] | s[0]), hpc_if_inst.irq);
                `TB_CHK("irq host", i[0], irq_host);
                `TB_CHK("irq push pull", 1'b0, hpc_if_inst.dev_irq_oe_n);
            end
        end
        cfg_irq_lo = 1'b0;
    endtask

    // 8-bit mode pins and registers
    task automatic t_narrow();
        int wc;
        bus16 = 1'b0;
        do_reset(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'he5);
        `TB_CHK("bus8", 1'b1, bus8);
        `TB_CHK("io inputs", 3'b101, hpc_if_inst.host_data_high[2:0]);
        wc = wr_cnt;
        wr_idx(`HPC_IDX_GP_DIR, 16'h0002);
        wr_idx(`HPC_IDX_GP_VAL, 16'h0050);
        `TB_CHK("internal writes", wc, wr_cnt);
        `TB_CHK("outputs", 3'b101, hpc_if_inst.host_data_high[5:3]);
        `TB_CHK("io pins", 3'b100, hpc_if_inst.host_data_high[2:0]);
        acc(1'b0, 1'b1, 16'h0000);
        `TB_CHK("gp read", 16'h0058, rdata & 16'h007e);
        `TB_CHK("upper read", 8'h00, rdata[15:8]);
        wr_idx(8'h05, 16'h12a7);
        `TB_CHK("narrow write", 16'h00a7, last_wd);
        for (int i = 0; i < 2; i++) begin
            wake_ev = i[0];
            irq_req = i[0];
            repeat (3) @(negedge clk_in);
            `TB_CHK("wake", i[0], hpc_if_inst.host_data_high[7]);
            `TB_CHK("irq open drain", i[0], hpc_if_inst.dev_irq_oe_n);
        end
        for (int i = 0; i < 4; i++) begin
            led_mode = i[1];
            fdx = i[0];
            spd10 = !i[0];
            repeat (3) @(negedge clk_in);
            `TB_CHK("led", i[1] ? !i[0] : i[0], hpc_if_inst.host_data_high[6]);
        end
    endtask

    //////////////////////////////////////////////////////////////////////
    // verdict
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        hpc_if_inst.irq_pull = 1'b0;
        t_access(1'b0);
        t_access(1'b1);
        t_refuse();
        t_irq();
        t_narrow();
        results();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        results();
    end
endmodule // host_port_pin_config_tb

`default_nettype wire
